/* rtl/rhp_pkg.sv */
/* rhp_pkg: constants and types of the reader host port.
   assumes: nothing beyond a SystemVerilog compiler. */
package rhp_pkg;
    localparam logic [4:0] A_CHIP = 5'h00;
    localparam logic [4:0] A_ISO = 5'h01;
    localparam logic [4:0] A_IRQ = 5'h0C;
    localparam logic [4:0] A_LVL = 5'h14;
    localparam logic [4:0] A_FSTAT = 5'h1C;
    localparam logic [4:0] A_TXL1 = 5'h1D;
    localparam logic [4:0] A_TXL2 = 5'h1E;
    localparam logic [4:0] A_FIFO = 5'h1F;
    localparam logic [4:0] C_INIT = 5'h03;
    localparam logic [4:0] C_FRST = 5'h0F;
    localparam int B_CMD = 7;
    localparam int B_RD = 6;
    localparam int B_CONT = 5;
    localparam int B_DIRECT = 6;
    localparam int B_DSEL = 6;
    localparam int IRQ_TX = 7;
    localparam int IRQ_RX = 6;
    localparam int IRQ_FIFO = 5;
    localparam int IRQ_CRC = 4;
    localparam int IRQ_FRAME = 2;
    localparam int P_D7 = 7;
    localparam int P_SS = 4;
    localparam int P_CLK = 8;
    localparam int P_MOD = 9;
    localparam logic [2:0] STRAP_SPI_SS = 3'h6;
    localparam logic [2:0] STRAP_SPI = 3'h4;
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    localparam logic [6:0] FIFO_DEPTH = 7'h7F;
    localparam logic [6:0] FIFO_LAST = 7'h7E;
    localparam logic [6:0] RX_ROOM = 7'h7E;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] OE_DM0 = 8'h40;
    localparam logic [7:0] OE_DM1 = 8'h60;
    localparam logic [7:0] OE_MISO = 8'h40;
    localparam logic [7:0] OE_PAR = 8'hFF;
    typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA, ST_DIRECT} rhp_state_t;
    typedef enum logic [1:0] {IF_PAR, IF_SPI, IF_SPI_SS} rhp_if_t;
endpackage

/* rtl/rhp_host_port.sv */
/* rhp_host_port: host port of a reader transceiver, parallel or SPI,
   with register file, 127-byte FIFO, transmit feed and direct mode.
   assumes: host pins are asynchronous and synchronised here; the
   receive/transmit core runs on i_sys_clk. */
`timescale 1ns/1ps
// Notes on behaviour
// (R1) parallel: d7 rising while clock high starts, resets interface
// (R2) host sends address word first, then data words
// (R3) d7 falling while clock high: simple stop, ends direct mode
// (R4) d7 rise then fall while clock low: continuous stop
// (R5) receive start of frame sets status bit 6
// (R6) receive end raises interrupt
// (R7) fifo above level during receive raises level interrupt, repeatable
// (R8) host reads status, fifo count, then fifo bytes
// (R9) receive framing or crc error sets its status flag
// (R10) host resets fifo before each transmit command
// (R11) host writes transmit length at 0x1D and 0x1E
// (R12) transmit length decides when end of frame is sent
// (R13) first fifo byte written starts transmission
// (R14) transmit start sets status bit 7; transmit end interrupts
// (R15) three strap lines pick interface variant at power-up
// (R16) status clears on the extra clock after its read
// (R17) dummy read: status then next register, continuous
// (R18) host sends soft init then idle when starting
// (R19) slave select high holds serial logic in reset
// (R20) eight-bit words, msb first, sampled on falling clock
// (R21) read data shifted out after eighth falling edge
// (R22) direct bit enters direct mode; stop leaves and clears it
// (R23) word bits: command, read, continuous, 5-bit code
// (R24) continuous mode increments address; single takes one word
// (R25) direct outputs: subcarrier, or decoded bit and bit clock
module rhp_host_port
    import rhp_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_data_clk,
    input wire logic [7:0] i_io_in,
    output logic [7:0] o_io_out,
    output logic [7:0] o_io_oe,
    input wire logic i_modulation_input,
    output logic o_mod_drive,
    output logic o_irq,
    input wire logic i_subcarrier,
    input wire logic i_dec_bit,
    input wire logic i_dec_bit_clk,
    input wire logic i_rx_sof,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_byte,
    output logic o_rx_ready,
    input wire logic i_rx_end,
    input wire logic i_rx_frame_err,
    input wire logic i_rx_crc_err,
    output logic o_tx_start,
    output logic [7:0] o_tx_byte,
    output logic o_tx_valid,
    input wire logic i_tx_ready,
    output logic o_tx_eof,
    input wire logic i_tx_done
);
    logic [9:0] s1_ff, s2_ff, s3_ff;
    rhp_if_t if_ff, nxt_if;
    rhp_state_t st_ff, nxt_st;
    logic [1:0] sw_ff, nxt_sw;
    logic ok_ff, nxt_ok, arm_ff, nxt_arm, clrp_ff, nxt_clrp;
    logic rd_ff, nxt_rd, cont_ff, nxt_cont, done_ff, nxt_done;
    logic [2:0] bit_ff, nxt_bit;
    logic [6:0] shi_ff, nxt_shi;
    logic [7:0] sho_ff, nxt_sho;
    logic [4:0] addr_ff, nxt_addr;
    logic [7:0] reg_ff [32];
    logic [7:0] nxt_reg [32];
    logic [7:0] mem_ff [127];
    logic [7:0] nxt_mem [127];
    logic [6:0] wp_ff, nxt_wp, rp_ff, nxt_rp, cnt_ff, nxt_cnt;
    logic ovf_ff, nxt_ovf, tact_ff, nxt_tact, ract_ff, nxt_ract;
    logic above_ff, nxt_above, rrdy_ff, nxt_rrdy;
    logic [11:0] left_ff, nxt_left;
    logic [7:0] b0_ff, nxt_b0, b1_ff, nxt_b1, irqs_ff, nxt_irqs, evset;
    logic v0_ff, nxt_v0, v1_ff, nxt_v1, start_ff, nxt_start;
    logic eof_ff, nxt_eof, irqo_ff, nxt_irqo, mod_ff, nxt_mod;
    logic [7:0] out_ff, nxt_out, oe_ff, nxt_oe, rdata, word_in;
    logic ss_spi, clk_h, clk_l, clk_e, clk_r, clk_f, d7_r, d7_f;
    logic start_ev, sstop_ev, cstop_ev, stop_ev, ss_hold, busy;
    logic word_ev, cmd_ev, adr_ev, rdl_ev, wr_ev, cont_now, clr_now;
    logic hw_push, hr_pop, frst, tx_go, push, full, wr_ok, tb_pop, pop;
    logic above_now, fifo_ev;
    logic [4:0] rd_a;

    // pin synchroniser: pins, link clock and modulation input
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= {i_modulation_input, i_data_clk, i_io_in};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    assign ss_spi = (if_ff == IF_SPI_SS);
    assign clk_h = s2_ff[P_CLK] & s3_ff[P_CLK];
    assign clk_l = ~s2_ff[P_CLK] & ~s3_ff[P_CLK];
    assign clk_e = s2_ff[P_CLK] ^ s3_ff[P_CLK];
    assign clk_r = s2_ff[P_CLK] & ~s3_ff[P_CLK];
    assign clk_f = ~s2_ff[P_CLK] & s3_ff[P_CLK];
    assign d7_r = s2_ff[P_D7] & ~s3_ff[P_D7];
    assign d7_f = ~s2_ff[P_D7] & s3_ff[P_D7];
    assign start_ev = ok_ff & (ss_spi ? (~s2_ff[P_SS] & s3_ff[P_SS])
                                      : (d7_r & clk_h));
    assign sstop_ev = ok_ff & (ss_spi ? (s2_ff[P_SS] & ~s3_ff[P_SS])
                                      : (d7_f & clk_h));
    assign cstop_ev = ok_ff & ~ss_spi & d7_f & clk_l & arm_ff; // [R4]
    assign stop_ev = sstop_ev | cstop_ev;
    assign ss_hold = ss_spi & s2_ff[P_SS];
    assign busy = (st_ff == ST_CMD) || (st_ff == ST_DATA);
    // parallel takes a word per rising clock, serial per eighth fall
    assign word_ev = busy & ((if_ff == IF_PAR) ? clk_r
                                               : (clk_f & &bit_ff));
    assign word_in = (if_ff == IF_PAR) ? s2_ff[7:0]
                                       : {shi_ff, s2_ff[P_D7]}; // [R20]
    assign cmd_ev = word_ev && st_ff == ST_CMD && word_in[B_CMD]; // [R23]
    assign adr_ev = word_ev && st_ff == ST_CMD && !word_in[B_CMD]; // [R2]
    assign rd_a = (st_ff == ST_CMD) ? word_in[4:0] : addr_ff;
    assign cont_now = (st_ff == ST_CMD) ? word_in[B_CONT] : cont_ff;
    assign rdl_ev = (adr_ev && word_in[B_RD])
                 || (word_ev && st_ff == ST_DATA && rd_ff && !done_ff);
    assign wr_ev = word_ev && st_ff == ST_DATA && !rd_ff && !done_ff;
    assign clr_now = clrp_ff & (word_ev | stop_ev); // [R16] [R17]
    assign frst = cmd_ev && (word_in[4:0] == C_FRST
                          || word_in[4:0] == C_INIT); // [R10] [R18]
    assign hw_push = wr_ev && addr_ff == A_FIFO;
    assign hr_pop = rdl_ev && rd_a == A_FIFO && cnt_ff != '0; // [R8]
    assign tx_go = hw_push && !tact_ff; // [R13]
    assign push = hw_push | (i_rx_valid & rrdy_ff);
    assign full = (cnt_ff == FIFO_DEPTH);
    assign wr_ok = push & ~full;
    assign tb_pop = tact_ff && left_ff != '0 && cnt_ff != '0
                 && !v1_ff && !hr_pop;
    assign pop = hr_pop | tb_pop;
    assign above_now = ract_ff && cnt_ff > reg_ff[A_LVL][6:0];
    assign fifo_ev = above_now & ~above_ff; // [R7]

    always_comb begin
        if (rd_a == A_IRQ) begin
            rdata = irqs_ff;
        end else if (rd_a == A_FSTAT) begin
            rdata = {ovf_ff, cnt_ff};
        end else if (rd_a == A_FIFO) begin
            rdata = mem_ff[rp_ff];
        end else begin
            rdata = reg_ff[rd_a];
        end
    end

    // interface protocol and register file
    always_comb begin
        nxt_sw = sw_ff;
        nxt_ok = ok_ff;
        nxt_if = if_ff;
        nxt_st = st_ff;
        nxt_bit = bit_ff;
        nxt_shi = shi_ff;
        nxt_sho = sho_ff;
        nxt_addr = addr_ff;
        nxt_rd = rd_ff;
        nxt_cont = cont_ff;
        nxt_done = done_ff;
        nxt_reg = reg_ff;
        nxt_clrp = (clr_now ? 1'b0 : clrp_ff)
                 | (rdl_ev && rd_a == A_IRQ); // [R16]
        nxt_arm = (clk_e | cstop_ev) ? 1'b0 : (arm_ff | (d7_r & clk_l));
        if (!ok_ff) begin
            nxt_sw = 2'(sw_ff + 2'h1);
            if (sw_ff == STRAP_WAIT) begin
                nxt_ok = 1'b1;
                if (s2_ff[2:0] == STRAP_SPI_SS) begin // [R15]
                    nxt_if = IF_SPI_SS;
                end else if (s2_ff[2:0] == STRAP_SPI) begin
                    nxt_if = IF_SPI;
                end else begin
                    nxt_if = IF_PAR;
                end
            end
        end else if (stop_ev) begin
            nxt_st = ST_IDLE; // [R3] [R4]
            nxt_bit = '0;
            nxt_reg[A_CHIP][B_DIRECT] = 1'b0; // [R22]
        end else if (ss_hold) begin
            nxt_st = ST_IDLE; // [R19]
            nxt_bit = '0;
        end else begin
            case (st_ff)
                ST_DIRECT: nxt_st = ST_DIRECT;
                ST_IDLE, ST_CMD, ST_DATA: begin
                    if (start_ev) begin
                        nxt_st = ST_CMD; // [R1]
                        nxt_bit = '0;
                        nxt_done = 1'b0;
                    end else if (busy) begin
                        if (if_ff != IF_PAR && clk_f) begin
                            nxt_bit = 3'(bit_ff + 3'h1); // [R20]
                            nxt_shi = {shi_ff[5:0], s2_ff[P_D7]};
                            nxt_sho = {sho_ff[6:0], 1'b0};
                        end
                        if (cmd_ev && word_in[4:0] == C_INIT) begin
                            for (int i = 0; i < 32; i++) begin
                                nxt_reg[i] = REG_RST; // [R18]
                            end
                        end
                        if (adr_ev) begin
                            nxt_st = ST_DATA; // [R2] [R23]
                            nxt_addr = word_in[4:0];
                            nxt_rd = word_in[B_RD];
                            nxt_cont = word_in[B_CONT];
                            nxt_done = 1'b0;
                        end
                        if (rdl_ev) begin
                            nxt_sho = rdata; // [R21]
                            // fifo address holds so a stream stays in fifo
                            nxt_addr = (rd_a == A_FIFO) ? A_FIFO
                                     : 5'(rd_a + 5'h01); // [R24]
                            nxt_done = ~cont_now;
                        end
                        if (wr_ev) begin
                            if (addr_ff != A_IRQ && addr_ff != A_FSTAT
                                && addr_ff != A_FIFO) begin
                                nxt_reg[addr_ff] = word_in; // [R11]
                            end
                            nxt_addr = (addr_ff == A_FIFO) ? A_FIFO
                                     : 5'(addr_ff + 5'h01); // [R24]
                            nxt_done = ~cont_ff;
                            if (addr_ff == A_CHIP && word_in[B_DIRECT]) begin
                                nxt_st = ST_DIRECT; // [R22]
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            sw_ff <= '0;
            ok_ff <= 1'b0;
            if_ff <= IF_PAR;
            st_ff <= ST_IDLE;
            bit_ff <= '0;
            shi_ff <= '0;
            sho_ff <= '0;
            addr_ff <= '0;
            rd_ff <= 1'b0;
            cont_ff <= 1'b0;
            done_ff <= 1'b0;
            arm_ff <= 1'b0;
            clrp_ff <= 1'b0;
        end else begin
            sw_ff <= nxt_sw;
            ok_ff <= nxt_ok;
            if_ff <= nxt_if;
            st_ff <= nxt_st;
            bit_ff <= nxt_bit;
            shi_ff <= nxt_shi;
            sho_ff <= nxt_sho;
            addr_ff <= nxt_addr;
            rd_ff <= nxt_rd;
            cont_ff <= nxt_cont;
            done_ff <= nxt_done;
            arm_ff <= nxt_arm;
            clrp_ff <= nxt_clrp;
        end
    end

    // fifo, transmit feed, status flags and pins
    always_comb begin
        nxt_mem = mem_ff;
        nxt_wp = wp_ff;
        nxt_rp = rp_ff;
        nxt_cnt = 7'(cnt_ff + {6'h00, wr_ok} - {6'h00, pop});
        nxt_ovf = ovf_ff | (push & full);
        nxt_tact = tact_ff;
        nxt_left = tb_pop ? 12'(left_ff - 12'h001) : left_ff;
        nxt_b0 = b0_ff;
        nxt_b1 = b1_ff;
        nxt_v0 = v0_ff;
        nxt_v1 = v1_ff;
        nxt_start = tx_go; // [R13]
        nxt_eof = 1'b0;
        nxt_ract = (ract_ff | i_rx_sof) & ~i_rx_end;
        nxt_above = above_now;
        evset = '0;
        evset[IRQ_RX] = i_rx_sof; // [R5]
        evset[IRQ_TX] = tx_go; // [R14]
        evset[IRQ_FIFO] = fifo_ev; // [R7]
        evset[IRQ_CRC] = i_rx_crc_err; // [R9]
        evset[IRQ_FRAME] = i_rx_frame_err; // [R9]
        nxt_irqs = (clr_now ? 8'h00 : irqs_ff) | evset;
        nxt_irqo = (clr_now ? 1'b0 : irqo_ff) | i_rx_end | fifo_ev
                 | i_tx_done | i_rx_crc_err | i_rx_frame_err; // [R6] [R14]
        if (frst) begin
            nxt_wp = '0;
            nxt_rp = '0;
            nxt_cnt = '0;
            nxt_ovf = 1'b0;
            nxt_tact = 1'b0;
            nxt_left = '0;
            nxt_v0 = 1'b0;
            nxt_v1 = 1'b0;
        end else begin
            if (wr_ok) begin
                nxt_mem[wp_ff] = hw_push ? word_in : i_rx_byte;
                nxt_wp = (wp_ff == FIFO_LAST) ? '0 : 7'(wp_ff + 7'h01);
            end
            if (pop) begin
                nxt_rp = (rp_ff == FIFO_LAST) ? '0 : 7'(rp_ff + 7'h01);
            end
            if (v0_ff && i_tx_ready) begin
                nxt_b0 = b1_ff;
                nxt_v0 = v1_ff;
                nxt_v1 = 1'b0;
            end
            if (tb_pop && !nxt_v0) begin
                nxt_b0 = mem_ff[rp_ff];
                nxt_v0 = 1'b1;
            end else if (tb_pop) begin
                nxt_b1 = mem_ff[rp_ff];
                nxt_v1 = 1'b1;
            end
            if (tx_go) begin
                nxt_tact = 1'b1; // [R11] [R12]
                nxt_left = 12'({reg_ff[A_TXL1], reg_ff[A_TXL2][7:4]}
                             + {11'h000, reg_ff[A_TXL2][3:0] != '0});
            end else if (tact_ff && left_ff == '0 && !v0_ff) begin
                nxt_tact = 1'b0;
                nxt_eof = 1'b1; // [R12]
            end
        end
        nxt_rrdy = nxt_cnt < RX_ROOM;
        nxt_out = '0;
        nxt_oe = '0;
        nxt_mod = 1'b0;
        case (st_ff)
            ST_DIRECT: begin
                nxt_mod = s2_ff[P_MOD]; // [R25]
                if (reg_ff[A_ISO][B_DSEL]) begin
                    nxt_out[6] = i_dec_bit;
                    nxt_out[5] = i_dec_bit_clk;
                    nxt_oe = OE_DM1;
                end else begin
                    nxt_out[6] = i_subcarrier;
                    nxt_oe = OE_DM0;
                end
            end
            ST_DATA: begin
                if (rd_ff && if_ff == IF_PAR) begin
                    nxt_out = sho_ff;
                    nxt_oe = s2_ff[P_CLK] ? '0 : OE_PAR;
                end else if (rd_ff) begin
                    nxt_out[6] = sho_ff[7]; // [R21]
                    nxt_oe = OE_MISO;
                end
            end
            ST_IDLE, ST_CMD: nxt_oe = '0;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
            ovf_ff <= 1'b0;
            tact_ff <= 1'b0;
            left_ff <= '0;
            b0_ff <= '0;
            b1_ff <= '0;
            v0_ff <= 1'b0;
            v1_ff <= 1'b0;
            start_ff <= 1'b0;
            eof_ff <= 1'b0;
            ract_ff <= 1'b0;
            above_ff <= 1'b0;
            rrdy_ff <= 1'b0;
            irqs_ff <= '0;
            irqo_ff <= 1'b0;
            out_ff <= '0;
            oe_ff <= '0;
            mod_ff <= 1'b0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
            ovf_ff <= nxt_ovf;
            tact_ff <= nxt_tact;
            left_ff <= nxt_left;
            b0_ff <= nxt_b0;
            b1_ff <= nxt_b1;
            v0_ff <= nxt_v0;
            v1_ff <= nxt_v1;
            start_ff <= nxt_start;
            eof_ff <= nxt_eof;
            ract_ff <= nxt_ract;
            above_ff <= nxt_above;
            rrdy_ff <= nxt_rrdy;
            irqs_ff <= nxt_irqs;
            irqo_ff <= nxt_irqo;
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
            mod_ff <= nxt_mod;
        end
    end

    for (genvar g = 0; g < 32; g++) begin : g_reg
        always_ff @(posedge i_sys_clk) begin
            reg_ff[g] <= i_reset ? REG_RST : nxt_reg[g];
        end
    end
    for (genvar g = 0; g < 127; g++) begin : g_mem
        always_ff @(posedge i_sys_clk) begin
            mem_ff[g] <= nxt_mem[g];
        end
    end

    assign o_io_out = out_ff;
    assign o_io_oe = oe_ff;
    assign o_mod_drive = mod_ff;
    assign o_irq = irqo_ff;
    assign o_rx_ready = rrdy_ff;
    assign o_tx_start = start_ff;
    assign o_tx_byte = b0_ff;
    assign o_tx_valid = v0_ff;
    assign o_tx_eof = eof_ff;

    property p_start;
        @(posedge i_sys_clk) disable iff (i_reset)
        (start_ev && st_ff != ST_DIRECT) |=> (st_ff == ST_CMD && bit_ff == '0);
    endproperty
    a_start: assert property (p_start) else $error("start not taken"); // [R1]
    property p_sstop;
        @(posedge i_sys_clk) disable iff (i_reset)
        sstop_ev |=> (st_ff == ST_IDLE && !reg_ff[A_CHIP][B_DIRECT]);
    endproperty
    a_sstop: assert property (p_sstop) else $error("stop missed"); // [R3]
    property p_cstop;
        @(posedge i_sys_clk) disable iff (i_reset)
        cstop_ev |-> $past(arm_ff) ##1 (st_ff == ST_IDLE && !arm_ff);
    endproperty
    a_cstop: assert property (p_cstop) else $error("cont stop"); // [R4]
    property p_sof;
        @(posedge i_sys_clk) disable iff (i_reset)
        i_rx_sof |=> irqs_ff[IRQ_RX];
    endproperty
    a_sof: assert property (p_sof) else $error("sof flag lost"); // [R5]
    property p_txgo;
        @(posedge i_sys_clk) disable iff (i_reset)
        tx_go |=> (tact_ff && o_tx_start && irqs_ff[IRQ_TX]) ##1 !o_tx_start;
    endproperty
    a_txgo: assert property (p_txgo) else $error("tx start"); // [R13]
    property p_hold;
        @(posedge i_sys_clk) disable iff (i_reset)
        ss_hold |=> (st_ff == ST_IDLE && bit_ff == '0);
    endproperty
    a_hold: assert property (p_hold) else $error("ss hold"); // [R19]
    property p_eof;
        @(posedge i_sys_clk) disable iff (i_reset)
        $rose(o_tx_eof) |-> (left_ff == '0 && !o_tx_valid && !tact_ff);
    endproperty
    a_eof: assert property (p_eof) else $error("early eof"); // [R12]
    property p_direct;
        @(posedge i_sys_clk) disable iff (i_reset)
        (wr_ev && addr_ff == A_CHIP && word_in[B_DIRECT] && !stop_ev
         && !ss_hold && !start_ev) |=> st_ff == ST_DIRECT;
    endproperty
    a_direct: assert property (p_direct) else $error("no direct"); // [R22]
    property p_cont;
        @(posedge i_sys_clk) disable iff (i_reset)
        (wr_ev && cont_ff && !stop_ev && !ss_hold && !start_ev)
            |=> addr_ff == (($past(addr_ff) == A_FIFO) ? A_FIFO
                            : 5'($past(addr_ff) + 5'h01));
    endproperty
    a_cont: assert property (p_cont) else $error("no increment"); // [R24]
endmodule

/* test/rhp_host_model.sv */
/* rhp_host_model: host side of the port, spi with select or parallel.
   assumes: bench wires o_drv onto the pins; i_miso is pin six. */
`timescale 1ns/1ps
module rhp_host_model (
    output logic o_clk,
    output logic [7:0] o_drv,
    input wire logic i_miso
);
    initial begin
        o_clk = 1'b0;
        o_drv = 8'h16;
    end
    task automatic sel(input logic on);
        o_drv[4] = ~on;
        #400;
    endtask
    // clock stands low between words; data changes on the rise
    task automatic xfer(input logic [7:0] w, output logic [7:0] rd);
        for (int i = 7; i >= 0; i--) begin
            o_clk = 1'b1;
            o_drv[7] = w[i];
            rd[i] = i_miso;
            o_drv[6] = ~i_miso;
            #200;
            o_clk = 1'b0;
            #200;
        end
    endtask
    task automatic strap(input logic [2:0] v);
        o_drv[2:0] = v;
    endtask
    // parallel start: line seven rises with clock high
    task automatic pstart;
        o_drv[7] = 1'b0;
        o_clk = 1'b1;
        #400;
        o_drv[7] = 1'b1;
        #200;
    endtask
    // parallel word: set while clock low, taken on the rise
    task automatic pword(input logic [7:0] w);
        o_clk = 1'b0;
        #200;
        o_drv = w;
        #200;
        o_clk = 1'b1;
        #200;
    endtask
    // line seven rise then fall; clock high at the fall unless cont
    task automatic pstop(input logic cont);
        o_clk = 1'b0;
        #200;
        o_drv[7] = 1'b1;
        #200;
        o_clk = ~cont;
        #200;
        o_drv[7] = 1'b0;
        #200;
    endtask
endmodule

/* test/rhp_host_port_tb_top.sv */
/* rhp_host_port_tb_top: bench of the host port over spi with select, then parallel.
   assumes: design asserts sit inside the design files. */
`timescale 1ns/1ps
module rhp_host_port_tb_top;
    logic clk, rst, dclk, modin, irq, modd, rxv, rxr, rxe, sof, fe, ce;
    logic txs, txv, eof, txd, sc, db, dbc, txr = 1'b0;
    logic [7:0] io, out, oe, drv, rxb, txb, r, st;
    int miscompares, comparisons, cyc, starts, eofs;
    logic [7:0] got[$];
    assign io = (oe & out) | (~oe & drv);
    rhp_host_model u_rhp_host_model (.o_clk(dclk), .o_drv(drv),
        .i_miso(io[6]));
    rhp_host_port u_rhp_host_port (.i_sys_clk(clk), .i_reset(rst),
        .i_data_clk(dclk), .i_io_in(io), .o_io_out(out), .o_io_oe(oe),
        .i_modulation_input(modin), .o_mod_drive(modd), .o_irq(irq),
        .i_subcarrier(sc), .i_dec_bit(db), .i_dec_bit_clk(dbc),
        .i_rx_sof(sof), .i_rx_valid(rxv), .i_rx_byte(rxb),
        .o_rx_ready(rxr), .i_rx_end(rxe), .i_rx_frame_err(fe),
        .i_rx_crc_err(ce), .o_tx_start(txs), .o_tx_byte(txb),
        .o_tx_valid(txv), .i_tx_ready(txr), .o_tx_eof(eof),
        .i_tx_done(txd));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // transmitter stalls every other cycle
    always @(posedge clk) begin
        txr <= ~txr;
        cyc <= cyc + 1;
        if (txs) starts++;
        if (eof) eofs++;
        if (txv && txr) got.push_back(txb);
        if (cyc == 20000) begin
            miscompares++;
            wrap_up;
        end
    end
    task automatic chk(input string n, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic p(ref logic sg);
        sg = 1'b1;
        w(1);
        sg = 1'b0;
    endtask
    task automatic x(input logic [7:0] v);
        u_rhp_host_model.xfer(v, r);
    endtask
    task automatic s(input logic on);
        u_rhp_host_model.sel(on);
    endtask
    task automatic rd(input logic [7:0] a);
        s(1);
        x(a);
        x(8'h00);
        s(0);
    endtask
    task automatic status_read;
        s(1);
        x(8'h6C);
        x(8'h00);
        st = r;
        x(8'h00);
        s(0);
    endtask
    task automatic t_regs;
        chk("oe_rst", 8'h00, oe);
        s(1);
        x(8'h83);
        x(8'h80);
        s(0);
        s(1);
        x(8'h14);
        x(8'h03);
        x(8'h09);
        s(0);
        rd(8'h54);
        chk("level", 8'h03, r);
        $display("test regs done");
    endtask
    task automatic t_rx;
        chk("rx_ready", 8'h01, {7'h00, rxr});
        p(sof);
        rxv = 1'b1;
        for (int i = 0; i < 5; i++) begin
            rxb = 8'h10 + 8'(i);
            w(1);
        end
        rxv = 1'b0;
        w(4);
        chk("irq_lvl", 8'h01, {7'h00, irq});
        status_read;
        chk("stat_rx", 8'h60, st);
        w(4);
        chk("irq_clr", 8'h00, {7'h00, irq});
        rd(8'h5C);
        chk("count", 8'h05, r);
        s(1);
        x(8'h7F);
        for (int i = 0; i < 5; i++) begin
            x(8'h00);
            chk("fifo", 8'h10 + 8'(i), r);
        end
        s(0);
        p(rxe);
        w(4);
        chk("irq_end", 8'h01, {7'h00, irq});
        p(ce);
        p(fe);
        status_read;
        chk("errs", 8'h14, st & 8'h14);
        $display("test rx done");
    endtask
    task automatic t_tx;
        s(1);
        x(8'h8F);
        s(0);
        got.delete();
        s(1);
        x(8'h3D);
        x(8'h00);
        x(8'h30);
        for (int i = 0; i < 3; i++) x(8'hA0 + 8'(i));
        s(0);
        w(40);
        chk("starts", 8'h01, 8'(starts));
        chk("eofs", 8'h01, 8'(eofs));
        chk("tx_n", 8'h03, 8'(got.size()));
        for (int i = 0; i < 3; i++) chk("tx_b", 8'hA0 + 8'(i), got[i]);
        p(txd);
        w(4);
        chk("irq_tx", 8'h01, {7'h00, irq});
        status_read;
        chk("stat_tx", 8'h80, st & 8'h80);
        $display("test tx done");
    endtask
    task automatic t_direct;
        for (int m = 0; m < 2; m++) begin
            rd(8'h00);
            s(1);
            x(8'h01);
            x(m[0] ? 8'h40 : 8'h00);
            s(0);
            s(1);
            x(8'h00);
            x(8'h40);
            {sc, db, dbc, modin} = {~m[0], m[0], 1'b1, 1'b1};
            w(6);
            chk("dm_io6", 8'h01, {7'h00, out[6] & oe[6]});
            chk("dm_oe5", {7'h00, m[0]}, {7'h00, oe[5]});
            chk("mod_on", 8'h01, {7'h00, modd});
            s(0);
            chk("mod_off", 8'h00, {7'h00, modd});
            rd(8'h40);
            chk("dm_bit", 8'h00, r & 8'h40);
        end
        $display("test direct done");
    endtask
    task automatic t_par;
        u_rhp_host_model.strap(3'h0);
        rst = 1'b1;
        w(2);
        rst = 1'b0;
        w(12);
        chk("par_rst", 8'h00, {7'h00, modd});
        for (int m = 0; m < 2; m++) begin
            u_rhp_host_model.pstart;
            u_rhp_host_model.pword(8'h00);
            u_rhp_host_model.pword(8'h40);
            w(4);
            chk("par_dm", 8'h01, {7'h00, modd});
            u_rhp_host_model.pstop(m[0]);
            w(4);
            chk("par_stop", 8'h00, {7'h00, modd});
        end
        $display("test parallel done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons,
            miscompares);
        if (miscompares == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        {modin, rxv, rxe, sof, fe, ce, txd, sc, db, dbc} = '0;
        rxb = 8'h00;
        w(8);
        rst = 1'b0;
        w(12);
        t_regs;
        t_rx;
        t_tx;
        t_direct;
        t_par;
        wrap_up;
    end
endmodule
